/* File: hdl/csr_pkg.sv */
package csr_pkg;

  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 8;
  localparam int ID_W      = 5;
  localparam int RW_COUNT  = 22;
  localparam int HEAD_BITS = 11;
  localparam int MUL_W     = 18;

  // register map
  localparam logic [4:0] ADDR_PROT_A     = 5'h00;
  localparam logic [4:0] ADDR_PROT_B     = 5'h01;
  localparam logic [4:0] ADDR_PROT_C     = 5'h02;
  localparam logic [4:0] ADDR_TRACKING   = 5'h03;
  localparam logic [4:0] ADDR_FREQ_SEL   = 5'h04;
  localparam logic [4:0] ADDR_ON_DELAY   = 5'h05;
  localparam logic [4:0] ADDR_OFF_DELAY  = 5'h06;
  localparam logic [4:0] ADDR_SETPOINT   = 5'h07;
  localparam logic [4:0] ADDR_CUR_LIMIT  = 5'h08;
  localparam logic [4:0] ADDR_DUTY_LIMIT = 5'h09;
  localparam logic [4:0] ADDR_DEN_1      = 5'h0a;
  localparam logic [4:0] ADDR_DEN_2      = 5'h0b;
  localparam logic [4:0] ADDR_DEN_3      = 5'h0c;
  localparam logic [4:0] ADDR_NUM0_LO    = 5'h0d;
  localparam logic [4:0] ADDR_NUM0_HI    = 5'h0e;
  localparam logic [4:0] ADDR_NUM1_LO    = 5'h0f;
  localparam logic [4:0] ADDR_NUM1_HI    = 5'h10;
  localparam logic [4:0] ADDR_NUM2_LO    = 5'h11;
  localparam logic [4:0] ADDR_NUM2_HI    = 5'h12;
  localparam logic [4:0] ADDR_NUM3_A     = 5'h13;
  localparam logic [4:0] ADDR_NUM3_B     = 5'h14;
  localparam logic [4:0] ADDR_SETUP_LAST = 5'h14;
  localparam logic [4:0] ADDR_RUN        = 5'h15;
  localparam logic [4:0] ADDR_STATUS     = 5'h16;
  localparam logic [4:0] ADDR_MEAS_V     = 5'h17;
  localparam logic [4:0] ADDR_MEAS_I     = 5'h18;
  localparam logic [4:0] ADDR_MEAS_T     = 5'h19;

  // power-up defaults of the writable registers
  localparam logic [7:0] REG_DEFAULT [RW_COUNT] = '{default: 8'h00};
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] REPLY_IDLE = 8'hff;

  // link timing
  localparam int REF_CLK_KHZ  = 250000;
  localparam int LINK_MIN_KHZ = 475;
  localparam int LINK_MAX_KHZ = 525;
  localparam int CNT_W        = 11;
  localparam logic [CNT_W-1:0] LINK_TIMEOUT_CYC =
    CNT_W'(2 * REF_CLK_KHZ / LINK_MIN_KHZ);
  localparam logic [MUL_W-1:0] PCT_FULL  = 18'h0_0064;
  localparam logic [MUL_W-1:0] PCT_SPLIT = 18'h0_0032;
  localparam logic [MUL_W-1:0] PCT_ZERO  = 18'h0_004b;

  // setpoint decode in half-millivolt units
  localparam int SP_W = 14;
  localparam logic [7:0]      SP_CODE1 = 8'h79;
  localparam logic [7:0]      SP_CODE2 = 8'hfb;
  localparam logic [SP_W-1:0] SP_BASE0 = 14'h03e8;
  localparam logic [SP_W-1:0] SP_STEP0 = 14'h0019;
  localparam logic [SP_W-1:0] SP_BASE1 = 14'h0fd2;
  localparam logic [SP_W-1:0] SP_STEP1 = 14'h0032;
  localparam logic [SP_W-1:0] SP_BASE2 = 14'h2968;
  localparam logic [SP_W-1:0] SP_STEP2 = 14'h0064;

  typedef enum logic [1:0] {
    CSR_IDLE  = 2'b00,
    CSR_HEAD  = 2'b01,
    CSR_WDATA = 2'b11,
    CSR_REPLY = 2'b10
  } csr_state_t;

  typedef struct packed {
    logic             wr;
    logic [ID_W-1:0]  id;
    logic [ADDR_W-1:0] addr;
  } csr_head_t;

  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] volt;
    logic [DATA_W-1:0] curr;
    logic [DATA_W-1:0] temp;
  } csr_monitor_t;

endpackage

/* File: hdl/csr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module csr_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_ff <= RESET_VALUE;
      sync_ff <= RESET_VALUE;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule
`default_nettype wire

/* File: hdl/csr_converter_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module csr_converter_regs
  import csr_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       sync_data_line_in,
  output logic                            sync_data_line_out,
  output logic                            sync_data_line_oe,
  input  wire logic                       strap_id_bit0,
  input  wire logic                       strap_id_bit1,
  input  wire logic                       strap_id_bit2,
  input  wire logic                       strap_id_bit3,
  input  wire logic                       strap_id_bit4,
  input  wire logic                       group_status_line_in,
  output logic                            group_status_line_out,
  output logic                            group_status_line_oe,
  input  wire logic                       group_fault_req,
  input  wire logic                       output_is_on,
  input  wire csr_monitor_t               monitor,
  output logic [RW_COUNT-1:0][DATA_W-1:0] setup_regs,
  output logic [ID_W-1:0]                 node_id,
  output logic                            id_valid,
  output logic                            sync_tick,
  output logic                            group_fault,
  output logic [SP_W-1:0]                 setpoint_half_mv,
  output logic [3:0][15:0]                filter_num,
  output logic                            write_done
);

  logic [6:0]        sync_q;
  logic              sd_s;
  logic              grp_s;
  logic [ID_W-1:0]   strap_s;
  logic              sd_prev_ff;
  logic              fall;
  logic              rise;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  last_period_ff;
  logic              timeout;
  logic              bit_ok;
  logic              bit_val;
  logic              drive_end;
  logic              drive_ff;
  logic              own_ff;
  csr_state_t        state_ff;
  logic [3:0]        bitcnt_ff;
  logic [HEAD_BITS-2:0] head_sr_ff;
  csr_head_t         head_next;
  csr_head_t         head_ff;
  logic              sel_ff;
  logic [DATA_W-1:0] data_sr_ff;
  logic [DATA_W-1:0] nxt_data;
  logic [DATA_W-1:0] reply_sr_ff;
  logic [DATA_W-1:0] rd_data;
  logic              commit;
  logic              locked_addr;
  logic              write_ok;
  logic [DATA_W-1:0] regs_ff [RW_COUNT];
  logic [ID_W-1:0]   node_id_ff;
  logic [1:0]        strap_wait_ff;
  logic              id_valid_ff;
  logic              grp_oe_ff;
  logic              grp_fault_ff;
  logic              tick_ff;
  logic              done_ff;
  logic [SP_W-1:0]   setpoint_ff;

  // pins pass two flops first
  csr_sync #(
    .WIDTH       (7),
    .RESET_VALUE (7'h7f)
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .din     ({sync_data_line_in, group_status_line_in, strap_id_bit4,
               strap_id_bit3, strap_id_bit2, strap_id_bit1,
               strap_id_bit0}),
    .dout    (sync_q)
  );

  assign sd_s    = sync_q[6];
  assign grp_s   = sync_q[5];
  assign strap_s = sync_q[4:0];

  // strap identity taken once the synchroniser has filled
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      strap_wait_ff <= 2'h0;
      node_id_ff    <= '0;
      id_valid_ff   <= 1'b0;
    end else if (strap_wait_ff != 2'h3) begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      if (strap_wait_ff == 2'h2) begin
        node_id_ff  <= strap_s;
        id_valid_ff <= 1'b1;
      end
    end
  end

  // line edges and period measurement
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sd_prev_ff <= 1'b1;
    end else begin
      sd_prev_ff <= sd_s;
    end
  end

  assign fall = sd_prev_ff & ~sd_s;
  assign rise = ~sd_prev_ff & sd_s;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      // an idle line since reset counts as timed out
      cnt_ff         <= LINK_TIMEOUT_CYC;
      last_period_ff <= '0;
    end else if (fall) begin
      cnt_ff         <= '0;
      last_period_ff <= cnt_ff;
    end else if (!timeout) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  assign timeout = (cnt_ff == LINK_TIMEOUT_CYC);

  // short low pulse is a one, long low pulse a zero
  assign bit_ok  = rise & ~own_ff;
  assign bit_val = !((MUL_W'(cnt_ff) * PCT_FULL) >
                     (MUL_W'(last_period_ff) * PCT_SPLIT));
  assign drive_end = (MUL_W'(cnt_ff) * PCT_FULL) >=
                     (MUL_W'(last_period_ff) * PCT_ZERO);

  // reply drive: stretch the manager's pulse to a zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      drive_ff <= 1'b0;
      own_ff   <= 1'b0;
    end else if (fall && state_ff == CSR_REPLY && !reply_sr_ff[7]) begin
      drive_ff <= 1'b1;
      own_ff   <= 1'b1;
    end else begin
      if (fall) begin
        own_ff <= 1'b0;
      end
      if (drive_ff && (drive_end || timeout)) begin
        drive_ff <= 1'b0;
      end
    end
  end

  assign sync_data_line_oe  = drive_ff;
  assign sync_data_line_out = 1'b0;

  assign head_next = csr_head_t'({head_sr_ff, bit_val});
  assign nxt_data  = {data_sr_ff[DATA_W-2:0], bit_val};

  // frame sequencer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff    <= CSR_IDLE;
      bitcnt_ff   <= 4'h0;
      head_sr_ff  <= '0;
      head_ff     <= '0;
      sel_ff      <= 1'b0;
      data_sr_ff  <= '0;
      reply_sr_ff <= REPLY_IDLE;
    end else if (timeout) begin
      state_ff    <= CSR_IDLE;
      reply_sr_ff <= REPLY_IDLE;
    end else begin
      unique case (state_ff)
        CSR_IDLE: begin
          if (bit_ok && !bit_val) begin
            state_ff  <= CSR_HEAD;
            bitcnt_ff <= 4'h0;
          end
        end
        CSR_HEAD: begin
          if (bit_ok) begin
            head_sr_ff <= head_next[HEAD_BITS-2:0];
            bitcnt_ff  <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'(HEAD_BITS - 1)) begin
              bitcnt_ff <= 4'h0;
              head_ff   <= head_next;
              sel_ff    <= id_valid_ff && (head_next.id == node_id_ff);
              if (head_next.wr) begin
                state_ff <= CSR_WDATA;
              end else begin
                state_ff    <= CSR_REPLY;
                reply_sr_ff <= (id_valid_ff &&
                                head_next.id == node_id_ff) ?
                               rd_data : REPLY_IDLE;
              end
            end
          end
        end
        CSR_WDATA: begin
          if (bit_ok) begin
            data_sr_ff <= nxt_data;
            bitcnt_ff  <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'(DATA_W - 1)) begin
              state_ff <= CSR_IDLE;
            end
          end
        end
        CSR_REPLY: begin
          if (fall) begin
            reply_sr_ff <= {reply_sr_ff[DATA_W-2:0], 1'b1};
            bitcnt_ff   <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'(DATA_W - 1)) begin
              state_ff <= CSR_IDLE;
            end
          end
        end
      endcase
    end
  end

  // read mux over the full map
  always_comb begin
    rd_data = READ_ZERO;
    if (head_next.addr < ADDR_W'(RW_COUNT)) begin
      rd_data = regs_ff[head_next.addr];
    end else begin
      unique case (head_next.addr)
        ADDR_STATUS: rd_data = monitor.status;
        ADDR_MEAS_V: rd_data = monitor.volt;
        ADDR_MEAS_I: rd_data = monitor.curr;
        ADDR_MEAS_T: rd_data = monitor.temp;
        default:     rd_data = READ_ZERO;
      endcase
    end
  end

  assign commit = (state_ff == CSR_WDATA) && bit_ok && !timeout &&
                  (bitcnt_ff == 4'(DATA_W - 1)) && sel_ff;

  assign locked_addr = (head_ff.addr == ADDR_FREQ_SEL) ||
                       (head_ff.addr == ADDR_DUTY_LIMIT) ||
                       ((head_ff.addr >= ADDR_DEN_1) &&
                        (head_ff.addr <= ADDR_NUM3_B));
  assign write_ok = (head_ff.addr <= ADDR_RUN) &&
                    !(locked_addr && output_is_on) &&
                    commit;

  // volatile storage, defaults back on every reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < RW_COUNT; i++) begin
        regs_ff[i] <= REG_DEFAULT[i];
      end
    end else if (write_ok) begin
      regs_ff[head_ff.addr] <= nxt_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      done_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      done_ff <= write_ok;
      tick_ff <= fall;
    end
  end

  // group status line: pull low on fault, report any member's fault
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      grp_oe_ff    <= 1'b0;
      grp_fault_ff <= 1'b0;
    end else begin
      grp_oe_ff    <= group_fault_req;
      grp_fault_ff <= ~grp_s;
    end
  end

  assign group_status_line_oe  = grp_oe_ff;
  assign group_status_line_out = 1'b0;

  // setpoint code to target voltage
  function automatic logic [SP_W-1:0] sp_decode(input logic [7:0] code);
    logic [SP_W-1:0] c;
    c = SP_W'(code);
    if (code < SP_CODE1) begin
      sp_decode = SP_BASE0 + c * SP_STEP0;
    end else if (code < SP_CODE2) begin
      sp_decode = SP_BASE1 + (c - SP_W'(SP_CODE1)) * SP_STEP1;
    end else begin
      sp_decode = SP_BASE2 + (c - SP_W'(SP_CODE2)) * SP_STEP2;
    end
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      setpoint_ff <= SP_BASE0;
    end else begin
      setpoint_ff <= sp_decode(regs_ff[ADDR_SETPOINT]);
    end
  end

  for (genvar g = 0; g < RW_COUNT; g++) begin : g_out
    assign setup_regs[g] = regs_ff[g];
  end

  // multi-byte numerator terms joined from their byte registers
  assign filter_num[0] = {regs_ff[ADDR_NUM0_HI],
                          regs_ff[ADDR_NUM0_LO]};
  assign filter_num[1] = {regs_ff[ADDR_NUM1_HI],
                          regs_ff[ADDR_NUM1_LO]};
  assign filter_num[2] = {regs_ff[ADDR_NUM2_HI],
                          regs_ff[ADDR_NUM2_LO]};
  assign filter_num[3] = {regs_ff[ADDR_NUM3_A],
                          regs_ff[ADDR_NUM3_B]};

  assign node_id          = node_id_ff;
  assign id_valid         = id_valid_ff;
  assign sync_tick        = tick_ff;
  assign group_fault      = grp_fault_ff;
  assign setpoint_half_mv = setpoint_ff;
  assign write_done       = done_ff;

endmodule
`default_nettype wire

/* File: sim/csr_converter_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module csr_converter_regs_monitor
  import csr_pkg::*;
(
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  input wire logic                       sync_data_line_out,
  input wire logic                       sync_data_line_oe,
  input wire logic                       strap_id_bit0,
  input wire logic                       strap_id_bit1,
  input wire logic                       strap_id_bit2,
  input wire logic                       strap_id_bit3,
  input wire logic                       strap_id_bit4,
  input wire logic                       group_status_line_in,
  input wire logic                       group_status_line_out,
  input wire logic                       group_status_line_oe,
  input wire logic                       group_fault_req,
  input wire logic                       output_is_on,
  input wire logic [RW_COUNT-1:0][DATA_W-1:0] setup_regs,
  input wire logic [ID_W-1:0]            node_id,
  input wire logic                       id_valid,
  input wire logic                       sync_tick,
  input wire logic                       group_fault,
  input wire logic [SP_W-1:0]            setpoint_half_mv,
  input wire logic [3:0][15:0]           filter_num,
  input wire logic                       write_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  function automatic logic [SP_W-1:0] sp_exp(input logic [7:0] c);
    if (c < SP_CODE1) return SP_BASE0 + SP_STEP0 * SP_W'(c);
    if (c < SP_CODE2) return SP_BASE1 + SP_STEP1 * SP_W'(c - SP_CODE1);
    return SP_BASE2 + SP_STEP2 * SP_W'(c - SP_CODE2);
  endfunction

  AST_OD_LOW: assert property (
    !sync_data_line_out && !group_status_line_out)
    else $error("open drain value not low");
  AST_OE_SHORT: assert property (
    $rose(sync_data_line_oe) |-> ##[1:40] !sync_data_line_oe)
    else $error("line held low too long");
  AST_TICK_PULSE: assert property (
    sync_tick |=> !sync_tick)
    else $error("tick longer than one cycle");
  AST_GRP_OE: assert property (
    $past(nrst) |-> group_status_line_oe == $past(group_fault_req))
    else $error("group drive not following request");
  AST_GRP_FAULT: assert property (
    !group_status_line_in [*4] |=> group_fault)
    else $error("group fault missed");
  AST_ID_LATCH: assert property (
    $rose(id_valid) |-> node_id == {strap_id_bit4, strap_id_bit3,
      strap_id_bit2, strap_id_bit1, strap_id_bit0})
    else $error("node id not strap value");
  AST_RST_DFLT: assert property (
    $rose(nrst) |-> setup_regs == '0 && setpoint_half_mv == SP_BASE0)
    else $error("defaults not restored");
  AST_LOCK: assert property (
    output_is_on |=> $stable(setup_regs[4]) && $stable(setup_regs[20:9]))
    else $error("locked register changed");
  AST_WDONE: assert property (
    write_done |=> !write_done)
    else $error("write done longer than one cycle");
  AST_SP_DEC: assert property (
    ($past(nrst) && $stable(setup_regs[7])) [*3] |->
      setpoint_half_mv == sp_exp(setup_regs[7]))
    else $error("setpoint decode wrong");
  AST_PAIR: assert property (
    $stable(setup_regs) |-> filter_num[0] == {setup_regs[14], setup_regs[13]}
      && filter_num[3] == {setup_regs[19], setup_regs[20]})
    else $error("numerator pairing wrong");

  CV_WRITE: cover property (write_done);
  CV_REPLY: cover property ($rose(sync_data_line_oe));
  CV_GROUP: cover property ($rose(group_fault));
endmodule

bind csr_converter_regs csr_converter_regs_monitor mon_u (
  .ref_clk, .nrst, .sync_data_line_out, .sync_data_line_oe,
  .strap_id_bit0, .strap_id_bit1, .strap_id_bit2, .strap_id_bit3,
  .strap_id_bit4, .group_status_line_in, .group_status_line_out,
  .group_status_line_oe, .group_fault_req, .output_is_on, .setup_regs,
  .node_id, .id_valid, .sync_tick, .group_fault, .setpoint_half_mv,
  .filter_num, .write_done
);
`default_nettype wire

/* File: sim/csr_pm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csr_pm_model (
  input  wire logic line_lvl,
  output logic      pm_pull
);
  initial pm_pull = 1'b0;

  // one 125 ns link period: sync pulse, then data or sample
  task automatic bit_io(input logic b, output logic s);
    pm_pull = 1'b1;
    #31;
    pm_pull = !b;
    #31;
    s = line_lvl;
    #32;
    pm_pull = 1'b0;
    #31;
  endtask

  // idle, start, wr, id, addr, data or reply, idle
  task automatic xfer(input logic wr, input logic [4:0] id,
                      input logic [4:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    logic [22:0] f;
    logic        s;
    f = {2'b11, 1'b0, wr, id, a, wr ? d : 8'hff, 1'b1};
    rd = 8'h00;
    for (int i = 22; i >= 0; i--) begin
      bit_io(f[i], s);
      if (i >= 1 && i <= 8) rd = {rd[6:0], s};
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import csr_pkg::*;
;
  localparam logic [4:0] ID = 5'h16;
  logic ref_clk, nrst, output_is_on, group_fault_req, grp_pull;
  logic strap_id_bit0, strap_id_bit1, strap_id_bit2;
  logic strap_id_bit3, strap_id_bit4;
  csr_monitor_t monitor;
  wire logic line_lvl, grp_lvl, sd_oe, gs_oe, id_valid, group_fault;
  wire logic write_done, pm_pull, sync_tick;
  wire logic [RW_COUNT-1:0][DATA_W-1:0] setup_regs;
  wire logic [ID_W-1:0] node_id;
  wire logic [SP_W-1:0] setpoint_half_mv;
  wire logic [3:0][15:0] filter_num;
  int n_errors, checks, n_wd, cyc, n_tk;
  logic [7:0] r;

  assign line_lvl = !(pm_pull | sd_oe);
  assign grp_lvl = !(grp_pull | gs_oe);

  csr_converter_regs dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .sync_data_line_in(line_lvl),
    .sync_data_line_out(), .sync_data_line_oe(sd_oe),
    .strap_id_bit0(strap_id_bit0), .strap_id_bit1(strap_id_bit1),
    .strap_id_bit2(strap_id_bit2), .strap_id_bit3(strap_id_bit3),
    .strap_id_bit4(strap_id_bit4), .group_status_line_in(grp_lvl),
    .group_status_line_out(), .group_status_line_oe(gs_oe),
    .group_fault_req(group_fault_req), .output_is_on(output_is_on),
    .monitor(monitor), .setup_regs(setup_regs), .node_id(node_id),
    .id_valid(id_valid), .sync_tick(sync_tick), .group_fault(group_fault),
    .setpoint_half_mv(setpoint_half_mv), .filter_num(filter_num),
    .write_done(write_done)
  );
  csr_pm_model pm_u (.line_lvl(line_lvl), .pm_pull(pm_pull));

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    pm_u.xfer(1'b1, ID, a, d, x);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    pm_u.xfer(1'b0, ID, a, 8'h00, q);
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("sp_dflt", setpoint_half_mv, 16'h03e8);
    for (int a = 0; a < RW_COUNT; a++)
      chk("dflt", setup_regs[a], 16'h0000);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (write_done === 1'b1) n_wd++;
    if (sync_tick === 1'b1) n_tk++;
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      test_done();
    end
  end

  localparam logic [7:0] SPC [6] = '{8'h00, 8'h78, 8'h79, 8'hfa, 8'hfb,
                                     8'hff};
  localparam logic [15:0] SPV [6] = '{16'h03e8, 16'h0fa0, 16'h0fd2,
                                      16'h2904, 16'h2968, 16'h2af8};
  localparam logic [4:0] LCK [4] = '{5'h04, 5'h09, 5'h0a, 5'h14};
  initial begin
    nrst = 1'b0;
    output_is_on = 1'b0;
    group_fault_req = 1'b0;
    grp_pull = 1'b0;
    monitor = 32'h5a3c_9617;
    {strap_id_bit4, strap_id_bit3, strap_id_bit2, strap_id_bit1,
     strap_id_bit0} = ID;
    do_reset();
    chk("node_id", node_id, 16'(ID));
    chk("id_valid", id_valid, 16'h0001);
    rd(5'h00, r);
    chk("rd_dflt", r, 16'h0000);
    chk("ticks", 16'(n_tk), 16'h0017);
    for (int a = 0; a < RW_COUNT; a++) wr(5'(a), 8'(8'h40 + a));
    for (int a = 0; a < RW_COUNT; a++) begin
      rd(5'(a), r);
      chk("rdback", r, 16'(8'h40 + a));
      chk("map", setup_regs[a], 16'(8'h40 + a));
    end
    chk("num0", filter_num[0], 16'h4e4d);
    chk("num3", filter_num[3], 16'h5354);
    for (int a = 22; a < 26; a++) begin
      rd(5'(a), r);
      chk("ro", r, 16'(monitor[31 - 8 * (a - 22) -: 8]));
    end
    wr(5'h16, 8'h00);
    rd(5'h16, r);
    chk("ro_wr", r, 16'h005a);
    rd(5'h1a, r);
    chk("unmap", r, 16'h0000);
    rd(5'h1f, r);
    chk("unmap", r, 16'h0000);
    pm_u.xfer(1'b1, ID ^ 5'h01, 5'h07, 8'h11, r);
    chk("other_id", setup_regs[7], 16'h0047);
    pm_u.xfer(1'b0, ID ^ 5'h01, 5'h07, 8'h00, r);
    chk("other_rd", r, 16'h00ff);
    @(posedge ref_clk);
    output_is_on <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(LCK[i], 8'hee);
      chk("lock", setup_regs[LCK[i]], 16'(8'h40 + LCK[i]));
    end
    for (int i = 0; i < 6; i++) begin
      wr(5'h07, SPC[i]);
      chk("sp_code", setup_regs[7], 16'(SPC[i]));
      chk("sp_mv", setpoint_half_mv, SPV[i]);
    end
    @(posedge ref_clk);
    output_is_on <= 1'b0;
    wr(5'h09, 8'h99);
    chk("unlock", setup_regs[9], 16'h0099);
    chk("wdone", 16'(n_wd), 16'h001d);
    @(posedge ref_clk);
    group_fault_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("grp_oe", gs_oe, 16'h0001);
    chk("grp_own", group_fault, 16'h0001);
    group_fault_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("grp_clr", group_fault, 16'h0000);
    grp_pull <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("grp_peer", group_fault, 16'h0001);
    grp_pull <= 1'b0;
    do_reset();
    test_done();
  end
endmodule
`default_nettype wire
